// [core/sys_ctrl_pkg.sv]
package sys_ctrl_pkg;

   // i/o decode
   localparam logic [15:0] PORT_ADDR        = 16'h0061;

   // write and read field positions
   localparam int          GATE_BIT         = 0;
   localparam int          SPEAKER_BIT      = 1;
   localparam int          PARITY_EN_N_BIT  = 2;
   localparam int          CHAN_EN_N_BIT    = 3;
   localparam int          REFRESH_BIT      = 4;
   localparam int          TIMER_OUT_BIT    = 5;
   localparam int          CHAN_ERR_BIT     = 6;
   localparam int          PARITY_ERR_BIT   = 7;

   // error latch slots
   localparam int          LATCH_PARITY     = 0;
   localparam int          LATCH_CHAN       = 1;
   localparam int          LATCH_COUNT      = 2;

   // values after reset
   localparam logic        GATE_RESET       = 1'b0;
   localparam logic        SPEAKER_RESET    = 1'b0;
   localparam logic        PARITY_EN_N_RST  = 1'b1;
   localparam logic        CHAN_EN_N_RST    = 1'b1;
   localparam logic        REFRESH_RESET    = 1'b0;
   localparam logic [7:0]  READ_DATA_RESET  = 8'h00;

   // read answer latency in clock cycles
   localparam int          READ_LATENCY     = 1;

endpackage : sys_ctrl_pkg

// [core/err_latch_if.sv]
interface err_latch_if #(
   parameter int N = 2
);
   logic [N-1:0] enableN;
   logic [N-1:0] errIn;
   logic [N-1:0] latched;

   modport ctrl  (output enableN, output errIn, input latched);
   modport latch (input enableN, input errIn, output latched);
endinterface : err_latch_if

// [core/error_latch_bank.sv]
module error_latch_bank #(
   parameter int N = 2
) (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   reset,
   // enables, error inputs and latched flags
   err_latch_if.latch  errs
);

   initial begin
      if (N < 1) begin
         $error("error_latch_bank needs at least one latch");
      end
   end

   typedef struct packed {
      logic [N-1:0] flags;
   } latch_state_t;

   latch_state_t state_reg;
   latch_state_t state_next;

   always_comb begin
      state_next = state_reg;
      for (int i = 0; i < N; i++) begin
         // set while enabled, held clear while disabled
         if (errs.enableN[i]) begin
            state_next.flags[i] = 1'b0;
         end else if (errs.errIn[i]) begin
            state_next.flags[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_out
         assign errs.latched[g] = state_reg.flags[g];

         latch_set_a : assert property (@(posedge clk) disable iff (reset)
            (!errs.enableN[g] && errs.errIn[g]) |=> errs.latched[g])
            else $error("error latch did not set");

         latch_clear_a : assert property (@(posedge clk) disable iff (reset)
            errs.enableN[g] |=> !errs.latched[g])
            else $error("error latch not cleared by disable");

         latch_stick_a : assert property (@(posedge clk) disable iff (reset)
            (errs.latched[g] && !errs.enableN[g]) |=> errs.latched[g])
            else $error("error latch dropped while enabled");
      end
   endgenerate

endmodule : error_latch_bank

// [core/system_control_port_b.sv]
module system_control_port_b #(
   parameter int ADDR_W = 16
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // host i/o bus
   input  wire logic [ADDR_W-1:0] ioAddr,
   input  wire logic              ioWr,
   input  wire logic              ioRd,
   input  wire logic [7:0]        ioWrData,
   output logic      [7:0]        ioRdData,
   output logic                   ioRdValid,
   // system events
   input  wire logic              refreshReq,
   input  wire logic              timer2Out,
   input  wire logic              parityErr,
   input  wire logic              chanCheckErr,
   // controls
   output logic                   timer2Gate,
   output logic                   speakerDataEn,
   output logic                   parityErrFlag,
   output logic                   chanCheckErrFlag
);

   initial begin
      if (ADDR_W < 16) begin
         $error("system_control_port_b needs a 16-bit i/o address");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic       gate;
      logic       speaker;
      logic       parityEnN;
      logic       chanEnN;
      logic       refreshToggle;
      logic       timerOut;
      logic [7:0] rdData;
      logic       rdValid;
   } port_state_t;

   port_state_t state_reg;
   port_state_t state_next;

   logic        hit;
   logic        wrHit;
   logic        rdHit;

   err_latch_if #(.N(sys_ctrl_pkg::LATCH_COUNT)) errs ();

   assign hit   = (ioAddr[15:0] == sys_ctrl_pkg::PORT_ADDR)
                  && ((ADDR_W == 16) || (ioAddr >> 16) == '0);
   assign wrHit = hit && ioWr;
   assign rdHit = hit && ioRd;

   ////////////////////////////////////////////////////////////////////////////
   // error latches

   assign errs.enableN[sys_ctrl_pkg::LATCH_PARITY] = state_reg.parityEnN;
   assign errs.enableN[sys_ctrl_pkg::LATCH_CHAN]   = state_reg.chanEnN;
   assign errs.errIn[sys_ctrl_pkg::LATCH_PARITY]   = parityErr;
   assign errs.errIn[sys_ctrl_pkg::LATCH_CHAN]     = chanCheckErr;

   error_latch_bank #(
      .N     (sys_ctrl_pkg::LATCH_COUNT)
   ) u_latches (
      .clk   (clk),
      .reset (reset),
      .errs  (errs.latch)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_next         = state_reg;
      state_next.rdValid = 1'b0;
      state_next.timerOut = timer2Out;
      if (refreshReq) begin
         state_next.refreshToggle = !state_reg.refreshToggle;
      end
      if (wrHit) begin
         state_next.gate      = ioWrData[sys_ctrl_pkg::GATE_BIT];
         state_next.speaker   = ioWrData[sys_ctrl_pkg::SPEAKER_BIT];
         state_next.parityEnN = ioWrData[sys_ctrl_pkg::PARITY_EN_N_BIT];
         state_next.chanEnN   = ioWrData[sys_ctrl_pkg::CHAN_EN_N_BIT];
      end
      if (rdHit) begin
         state_next.rdValid = 1'b1;
         state_next.rdData[sys_ctrl_pkg::GATE_BIT]        = state_reg.gate;
         state_next.rdData[sys_ctrl_pkg::SPEAKER_BIT]     = state_reg.speaker;
         state_next.rdData[sys_ctrl_pkg::PARITY_EN_N_BIT] = state_reg.parityEnN;
         state_next.rdData[sys_ctrl_pkg::CHAN_EN_N_BIT]   = state_reg.chanEnN;
         state_next.rdData[sys_ctrl_pkg::REFRESH_BIT]     = state_reg.refreshToggle;
         state_next.rdData[sys_ctrl_pkg::TIMER_OUT_BIT]   = state_reg.timerOut;
         state_next.rdData[sys_ctrl_pkg::CHAN_ERR_BIT]    =
            errs.latched[sys_ctrl_pkg::LATCH_CHAN];
         state_next.rdData[sys_ctrl_pkg::PARITY_ERR_BIT]  =
            errs.latched[sys_ctrl_pkg::LATCH_PARITY];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg.gate          <= sys_ctrl_pkg::GATE_RESET;
         state_reg.speaker       <= sys_ctrl_pkg::SPEAKER_RESET;
         state_reg.parityEnN     <= sys_ctrl_pkg::PARITY_EN_N_RST;
         state_reg.chanEnN       <= sys_ctrl_pkg::CHAN_EN_N_RST;
         state_reg.refreshToggle <= sys_ctrl_pkg::REFRESH_RESET;
         state_reg.timerOut      <= 1'b0;
         state_reg.rdData        <= sys_ctrl_pkg::READ_DATA_RESET;
         state_reg.rdValid       <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign ioRdData         = state_reg.rdData;
   assign ioRdValid        = state_reg.rdValid;
   assign timer2Gate       = state_reg.gate;
   assign speakerDataEn    = state_reg.speaker;
   assign parityErrFlag    = errs.latched[sys_ctrl_pkg::LATCH_PARITY];
   assign chanCheckErrFlag = errs.latched[sys_ctrl_pkg::LATCH_CHAN];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence port_write_s;
      ioWr && hit && !ioRd;
   endsequence

   sequence port_read_s;
      ioRd && hit && !ioWr;
   endsequence

   read_decode_a : assert property (@(posedge clk) disable iff (reset)
      ioRdValid |-> $past(ioRd) && ($past(ioAddr[15:0]) == 16'h0061))
      else $error("read answered for a foreign address");

   write_decode_a : assert property (@(posedge clk) disable iff (reset)
      (ioWr && !hit) |=> $stable(timer2Gate) && $stable(speakerDataEn))
      else $error("foreign write changed the controls");

   gate_follow_a : assert property (@(posedge clk) disable iff (reset)
      port_write_s |=> timer2Gate == $past(ioWrData[0]))
      else $error("timer gate does not follow written bit 0");

   // gate held off after a zero write
   gate_stop_a : assert property (@(posedge clk) disable iff (reset)
      (port_write_s ##0 !ioWrData[0]) |=> !timer2Gate ##1 (!timer2Gate || $past(wrHit)))
      else $error("timer gate still active after a zero write");

   speaker_en_a : assert property (@(posedge clk) disable iff (reset)
      port_write_s |=> speakerDataEn == $past(ioWrData[1]))
      else $error("speaker enable does not follow written bit 1");

   speaker_reset_a : assert property (@(posedge clk)
      reset |=> !speakerDataEn && !timer2Gate)
      else $error("speaker enable not cleared by reset");

   parity_reset_a : assert property (@(posedge clk)
      reset |=> state_reg.parityEnN ##0 !parityErrFlag)
      else $error("parity check enable not disabled by reset");

   chan_reset_a : assert property (@(posedge clk)
      reset |=> state_reg.chanEnN ##0 !chanCheckErrFlag)
      else $error("channel check enable not disabled by reset");

   readback_a : assert property (@(posedge clk) disable iff (reset)
      (port_write_s ##1 (port_read_s and !wrHit)) |=>
         ioRdValid && ioRdData[3:0] == $past(ioWrData[3:0], 2))
      else $error("low nibble does not read back the last write");

   refresh_toggle_a : assert property (@(posedge clk) disable iff (reset)
      refreshReq |=> state_reg.refreshToggle != $past(state_reg.refreshToggle))
      else $error("refresh bit did not invert");

   refresh_hold_a : assert property (@(posedge clk) disable iff (reset)
      !refreshReq |=> $stable(state_reg.refreshToggle))
      else $error("refresh bit moved without a request");

   // timer output reported two cycles on
   timer_read_a : assert property (@(posedge clk) disable iff (reset)
      (port_read_s ##0 $past(timer2Out) == timer2Out) |=>
         ioRdData[5] == $past(timer2Out))
      else $error("timer output bit wrong on read");

   chan_read_a : assert property (@(posedge clk) disable iff (reset)
      port_read_s |=> ioRdData[6] == $past(chanCheckErrFlag))
      else $error("channel error bit wrong on read");

   parity_read_a : assert property (@(posedge clk) disable iff (reset)
      port_read_s |=> ioRdData[7] == $past(parityErrFlag))
      else $error("parity error bit wrong on read");

   // writing enable high clears the latch
   latch_clear_a : assert property (@(posedge clk) disable iff (reset)
      (port_write_s ##0 ioWrData[2]) |=> ##1 !parityErrFlag)
      else $error("parity latch not cleared by disable write");

   // upper write bits have no effect
   upper_ignore_a : assert property (@(posedge clk) disable iff (reset)
      (port_write_s ##0 !refreshReq) |=> $stable(state_reg.refreshToggle))
      else $error("upper write bits changed the refresh bit");

   // read answer is a one-cycle pulse
   valid_pulse_a : assert property (@(posedge clk) disable iff (reset)
      ioRdValid |=> (!ioRdValid || $past(rdHit)))
      else $error("read valid held without a new read");

   foreign_read_a : assert property (@(posedge clk) disable iff (reset)
      (ioRd && !hit) |=> !ioRdValid)
      else $error("read answered for a foreign address");

   reset_read_a : assert property (@(posedge clk)
      reset |=> !ioRdValid ##0 (ioRdData == sys_ctrl_pkg::READ_DATA_RESET))
      else $error("read data not cleared by reset");

   read_hold_a : assert property (@(posedge clk) disable iff (reset)
      !rdHit |=> $stable(ioRdData))
      else $error("read data moved without a read");

   gate_read_a : assert property (@(posedge clk) disable iff (reset)
      port_read_s |=> ioRdData[0] == $past(timer2Gate))
      else $error("gate bit wrong on read");

   speaker_read_a : assert property (@(posedge clk) disable iff (reset)
      port_read_s |=> ioRdData[1] == $past(speakerDataEn))
      else $error("speaker bit wrong on read");

   enables_read_a : assert property (@(posedge clk) disable iff (reset)
      port_read_s |=> ioRdData[3:2] == $past({state_reg.chanEnN, state_reg.parityEnN}))
      else $error("check enable bits wrong on read");

   // enables follow bits 2 and 3
   enable_write_a : assert property (@(posedge clk) disable iff (reset)
      port_write_s |=> (state_reg.parityEnN == $past(ioWrData[2]))
         && (state_reg.chanEnN == $past(ioWrData[3])))
      else $error("check enables do not follow written bits");

   refresh_read_a : assert property (@(posedge clk) disable iff (reset)
      port_read_s |=> ioRdData[4] == $past(state_reg.refreshToggle))
      else $error("refresh bit wrong on read");

   chan_set_a : assert property (@(posedge clk) disable iff (reset)
      (!state_reg.chanEnN && chanCheckErr) |=> chanCheckErrFlag)
      else $error("channel latch did not set");

   parity_set_a : assert property (@(posedge clk) disable iff (reset)
      (!state_reg.parityEnN && parityErr) |=> parityErrFlag)
      else $error("parity latch did not set");

   parity_stick_a : assert property (@(posedge clk) disable iff (reset)
      (parityErrFlag && !state_reg.parityEnN) |=> parityErrFlag)
      else $error("parity latch dropped while enabled");

   // writing channel enable high clears it
   chan_clear_a : assert property (@(posedge clk) disable iff (reset)
      (port_write_s ##0 ioWrData[3]) |=> ##1 !chanCheckErrFlag)
      else $error("channel latch not cleared by disable write");

endmodule : system_control_port_b

// [tb/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // clock and reset
   logic        clk        = 1'b0;
   logic        reset      = 1'b1;
   // bus and events
   logic [15:0] ioAddr     = 16'h0000;
   logic        ioWr       = 1'b0;
   logic        ioRd       = 1'b0;
   logic [7:0]  ioWrData   = 8'h00;
   logic        refreshReq = 1'b0;
   logic        timer2Out  = 1'b0;
   logic        parityErr  = 1'b0;
   logic        chanCheckErr = 1'b0;
   // design outputs
   logic [7:0]  ioRdData;
   logic        ioRdValid;
   logic        timer2Gate;
   logic        speakerDataEn;
   logic        parityErrFlag;
   logic        chanCheckErrFlag;
   // bench state
   int          n_fail     = 0;
   int          checked    = 0;
   logic [31:0] seed       = 32'h8d7b_e22b;
   logic [3:0]  expCtl     = 4'hC;
   logic        expRefr    = 1'b0;
   logic        expTmr     = 1'b0;
   logic        expPar     = 1'b0;
   logic        expChan    = 1'b0;

   always #4 clk = ~clk;

   system_control_port_b uut (
      .clk(clk), .reset(reset), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
      .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
      .refreshReq(refreshReq), .timer2Out(timer2Out), .parityErr(parityErr),
      .chanCheckErr(chanCheckErr), .timer2Gate(timer2Gate),
      .speakerDataEn(speakerDataEn), .parityErrFlag(parityErrFlag),
      .chanCheckErrFlag(chanCheckErrFlag));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   function automatic logic [7:0] expRead();
      return {expPar, expChan, expTmr, expRefr, expCtl};
   endfunction : expRead

   task automatic cmpByte(input string name, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask : cmpByte

   task automatic cmpBit(input string name, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %b seen %b", name, e, g);
      end
   endtask : cmpBit

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      ioAddr   <= a;
      ioWrData <= d;
      ioWr     <= 1'b1;
      @(posedge clk);
      ioWr     <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      ioAddr <= a;
      ioRd   <= 1'b1;
      @(posedge clk);
      ioRd   <= 1'b0;
      #1;
      d = ioRdData;
      v = ioRdValid;
   endtask : rd

   task automatic rdChk();
      logic [7:0] d;
      logic       v;
      rd(sys_ctrl_pkg::PORT_ADDR, d, v);
      cmpBit("ioRdValid", 1'b1, v);
      cmpByte("ioRdData", expRead(), d);
   endtask : rdChk

   task automatic wrRd(input logic [7:0] wd, output logic [7:0] q, output logic v);
      @(posedge clk);
      ioAddr   <= sys_ctrl_pkg::PORT_ADDR;
      ioWrData <= wd;
      ioWr     <= 1'b1;
      @(posedge clk);
      ioWr     <= 1'b0;
      ioRd     <= 1'b1;
      @(posedge clk);
      ioRd     <= 1'b0;
      #1;
      q = ioRdData;
      v = ioRdValid;
   endtask : wrRd

   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 0) parityErr <= 1'b1;
      else chanCheckErr <= 1'b1;
      @(posedge clk);
      parityErr    <= 1'b0;
      chanCheckErr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : pulse

   task automatic summarize();
      $display("counts: checked %0d failed %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end

   initial begin
      logic [7:0]  d;
      logic        v;
      logic [31:0] r;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      cmpBit("timer2Gate", 1'b0, timer2Gate);
      cmpBit("speakerDataEn", 1'b0, speakerDataEn);
      rdChk();
      $display("test reset done");
      for (int i = 0; i < 20; i++) begin
         r = rnd();
         d = (i == 0) ? 8'hF0 : (i == 1) ? 8'h0F : r[7:0];
         wr(sys_ctrl_pkg::PORT_ADDR, d);
         expCtl = d[3:0];
         cmpBit("timer2Gate", d[0], timer2Gate);
         cmpBit("speakerDataEn", d[1], speakerDataEn);
         rdChk();
      end
      r = rnd();
      wrRd(r[7:0], d, v);
      expCtl = r[3:0];
      cmpBit("timer2Gate", r[0], timer2Gate);
      cmpBit("ioRdValid", 1'b1, v);
      cmpByte("ioRdData", expRead(), d);
      $display("test writes done");
      wr(16'h0060, {4'h0, ~expCtl});
      wr(16'h1061, {4'h0, ~expCtl});
      cmpBit("timer2Gate", expCtl[0], timer2Gate);
      rd(16'h0062, d, v);
      cmpBit("ioRdValid", 1'b0, v);
      rdChk();
      $display("test decode done");
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         @(posedge clk);
         refreshReq <= 1'b1;
         repeat (r[1:0]) @(posedge clk);
         @(posedge clk);
         refreshReq <= 1'b0;
         expRefr ^= ~r[0];
         rdChk();
      end
      $display("test refresh done");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         timer2Out <= i[0] ^ 1'b1;
         repeat (3) @(posedge clk);
         expTmr = i[0] ^ 1'b1;
         rdChk();
      end
      $display("test timer done");
      wr(sys_ctrl_pkg::PORT_ADDR, 8'h0C);
      expCtl = 4'hC;
      pulse(0);
      pulse(1);
      rdChk();
      wr(sys_ctrl_pkg::PORT_ADDR, 8'h01);
      expCtl = 4'h1;
      pulse(0);
      expPar = 1'b1;
      cmpBit("parityErrFlag", 1'b1, parityErrFlag);
      rdChk();
      pulse(1);
      expChan = 1'b1;
      cmpBit("chanCheckErrFlag", 1'b1, chanCheckErrFlag);
      rdChk();
      wr(sys_ctrl_pkg::PORT_ADDR, 8'h05);
      repeat (2) @(posedge clk);
      expCtl = 4'h5;
      expPar = 1'b0;
      pulse(0);
      cmpBit("parityErrFlag", 1'b0, parityErrFlag);
      rdChk();
      wr(sys_ctrl_pkg::PORT_ADDR, 8'h0F);
      repeat (2) @(posedge clk);
      expCtl = 4'hF;
      expChan = 1'b0;
      rdChk();
      $display("test latches done");
      @(posedge clk);
      timer2Out <= 1'b0;
      reset     <= 1'b1;
      repeat (2) @(posedge clk);
      reset     <= 1'b0;
      expCtl  = 4'hC;
      expRefr = 1'b0;
      expTmr  = 1'b0;
      @(posedge clk);
      #1;
      cmpBit("speakerDataEn", 1'b0, speakerDataEn);
      rdChk();
      $display("test second reset done");
      summarize();
   end

endmodule : tb
